/* File: src/acsi_cfg.svh */
// acsi_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and both ends by bare name
`ifndef ACSI_CFG_SVH
`define ACSI_CFG_SVH

`define ACSI_ADDR_W          7
`define ACSI_DATA_W          32
`define ACSI_CHAN_W          5
`define ACSI_SEQ_ADDR_W      1
`define ACSI_SLOTS           64
`define ACSI_SAMPLE_W        12
`define ACSI_OFF_CMD         7'h00
`define ACSI_OFF_IER         7'h40
`define ACSI_OFF_ISR         7'h41
`define ACSI_OFF_EVT         7'h42
`define ACSI_OFF_THR         7'h43
`define ACSI_BIT_RUN         0
`define ACSI_BIT_EOP         0
`define ACSI_IER_RST         1'h1
`define ACSI_CHAN_TEMP       5'h11
`define ACSI_CHAN_LAST       5'h11
`define ACSI_MIN_CLK_KHZ     25000
`define ACSI_CLK_KHZ         20000

`endif

/* File: src/acsi_pkg.sv */
// acsi_pkg.sv: shared types of the side interfaces
// assumes: acsi_cfg.svh on the include path
`include "acsi_cfg.svh"
package acsi_pkg;
  typedef logic [`ACSI_CHAN_W-1:0]  acsi_chan_t;
  typedef logic [`ACSI_ADDR_W-1:0]  acsi_addr_t;
  typedef logic [`ACSI_DATA_W-1:0]  acsi_word_t;
  typedef logic [`ACSI_SAMPLE_W-1:0] acsi_sample_t;
  typedef enum logic {ACSI_BELOW_MIN, ACSI_ABOVE_MAX} acsi_viol_t;
  typedef enum {ACSI_H_IDLE, ACSI_H_READ_ISR, ACSI_H_CLEAR} acsi_host_state_t;
endpackage : acsi_pkg

/* File: src/acsi_if.sv */
// acsi_if.sv: threshold stream, register slave port and interrupt between ends
// assumes: both ends share clock and sys_rst
`timescale 1ns/1ns
`default_nettype none
interface acsi_if;
  import acsi_pkg::*;
  logic        thrValid;
  acsi_chan_t  thrChannel;
  acsi_viol_t  thrType;
  acsi_addr_t  regAddress;
  logic        regRead;
  logic        regWrite;
  acsi_word_t  regWriteData;
  acsi_word_t  regReadData;
  logic        irq;
  modport device (output thrValid, output thrChannel, output thrType,
                  input regAddress, input regRead, input regWrite, input regWriteData,
                  output regReadData, output irq);
  modport host   (input thrValid, input thrChannel, input thrType,
                  output regAddress, output regRead, output regWrite, output regWriteData,
                  input regReadData, input irq);
endinterface : acsi_if
`default_nettype wire

/* File: src/acsi_device.sv */
// acsi_device.sv: converter controller end with threshold stream, register slave, irq
// assumes: one clock for all micro cores, release of sys_rst synchronous to it
// limitation: slots hold one 12-bit sample; the command mode field is not modelled
// limitation: irq is a level, it stays up until the flag is cleared or masked
//
// Overview of operation
// - threshold stream has no ready, never stalls
// - 5-bit channel: 0..16 inputs, 17 temperature
// - violation type: 1 above max, 0 below min
// - register slave: read/write strobes, 32-bit data
// - word addresses: 7 bits store, 1 bit sequencer
// - one single-bit interrupt request output
// - one peripheral clock, at least 25 MHz (ACSI_CLK_KHZ and the testbench clock give 20 MHz)
// - one reset clears all micro cores (the sample store has no reset)
// - reset released synchronously by its source
// - converter clock from dedicated pll output zero
// - irq only when flag and enable both set
`include "acsi_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module acsi_device #(
  parameter int SLOTS = `ACSI_SLOTS
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  acsi_if.device             bus,
  input  wire logic          sampleValid,
  input  wire acsi_pkg::acsi_chan_t   sampleChannel,
  input  wire acsi_pkg::acsi_sample_t sampleData,
  input  wire logic          sampleEnd,
  output logic               runLevel
);
  import acsi_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(acsi_addr_t a, acsi_addr_t off);
    return a == off;
  endfunction : hit

  // sequencer sits at word 0 of its own 1-bit space; folded here
  logic wrCmd, wrIer, wrIsr, wrThr;
  assign wrCmd = bus.regWrite && hit(bus.regAddress, `ACSI_OFF_CMD);
  assign wrIer = bus.regWrite && hit(bus.regAddress, `ACSI_OFF_IER);
  assign wrIsr = bus.regWrite && hit(bus.regAddress, `ACSI_OFF_ISR);
  assign wrThr = bus.regWrite && hit(bus.regAddress, `ACSI_OFF_THR);

  // ----------------------------------------
  // state
  // ----------------------------------------
  acsi_sample_t store [SLOTS];
  logic [5:0]   slot_q, slot_d;
  logic         run_q, run_d;
  logic         ier_q, ier_d;
  logic         eop_q, eop_d;
  acsi_sample_t maxThr_q, maxThr_d, minThr_q, minThr_d;
  logic         tv_q, tv_d;
  acsi_chan_t   tc_q, tc_d;
  acsi_viol_t   tt_q, tt_d;
  logic [15:0]  evCnt_q, evCnt_d;
  acsi_word_t   rd_q, rd_d;
  logic         aboveMax, belowMin, chanOk;
  logic         storeWe;

  // codes 18..31 are unused: such samples are stored but never flagged
  assign chanOk   = sampleChannel <= `ACSI_CHAN_LAST;
  // with max below min both tests may pass; above max is then reported
  assign aboveMax = sampleData > maxThr_q;
  assign belowMin = sampleData < minThr_q;
  assign storeWe  = !sys_rst && sampleValid && run_q;

  // ----------------------------------------
  // register group: run, enable, status, thresholds
  // ----------------------------------------
  always_comb begin
    run_d    = run_q;
    ier_d    = ier_q;
    eop_d    = eop_q;
    maxThr_d = maxThr_q;
    minThr_d = minThr_q;
    if (wrCmd) begin
      run_d = bus.regWriteData[`ACSI_BIT_RUN];
    end
    if (wrIer) begin
      ier_d = bus.regWriteData[`ACSI_BIT_EOP];
    end
    if (wrThr) begin
      maxThr_d = bus.regWriteData[27:16];
      minThr_d = bus.regWriteData[11:0];
    end
    // write-one clears; a packet end in the same cycle wins
    if (wrIsr && bus.regWriteData[`ACSI_BIT_EOP]) begin
      eop_d = 1'b0;
    end
    if (sampleValid && run_q && sampleEnd) begin
      eop_d = 1'b1;
    end
  end

  // ----------------------------------------
  // sample path: slot pointer and threshold stream
  // ----------------------------------------
  always_comb begin
    slot_d  = slot_q;
    evCnt_d = evCnt_q;
    tv_d    = 1'b0;
    tc_d    = tc_q;
    tt_d    = tt_q;
    if (sampleValid && run_q) begin
      slot_d = sampleEnd ? 6'h00 : slot_q + 6'h01;
      if (chanOk && (aboveMax || belowMin)) begin
        tv_d    = 1'b1;
        tc_d    = sampleChannel;
        tt_d    = aboveMax ? ACSI_ABOVE_MAX : ACSI_BELOW_MIN;
        evCnt_d = evCnt_q + 16'h0001;
      end
    end
  end

  always_comb begin
    rd_d = '0;
    if (bus.regRead) begin
      if (bus.regAddress < 7'(SLOTS)) begin
        rd_d = acsi_word_t'(store[bus.regAddress[5:0]]);
      end else if (hit(bus.regAddress, `ACSI_OFF_IER)) begin
        rd_d = acsi_word_t'(ier_q);
      end else if (hit(bus.regAddress, `ACSI_OFF_ISR)) begin
        rd_d = acsi_word_t'(eop_q);
      end else if (hit(bus.regAddress, `ACSI_OFF_EVT)) begin
        rd_d = acsi_word_t'(evCnt_q);
      end else if (hit(bus.regAddress, `ACSI_OFF_THR)) begin
        rd_d = {4'h0, maxThr_q, 4'h0, minThr_q};
      end else begin
        rd_d = '0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // single synchronous reset clears every micro core together but the sample store
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_q    <= 1'b0;
      ier_q    <= `ACSI_IER_RST;
      eop_q    <= 1'b0;
      maxThr_q <= 12'hFFF;
      minThr_q <= 12'h000;
    end else begin
      run_q    <= run_d;
      ier_q    <= ier_d;
      eop_q    <= eop_d;
      maxThr_q <= maxThr_d;
      minThr_q <= minThr_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_q   <= 6'h00;
      tv_q     <= 1'b0;
      tc_q     <= 5'h00;
      tt_q     <= ACSI_BELOW_MIN;
      evCnt_q  <= 16'h0000;
    end else begin
      slot_q   <= slot_d;
      tv_q     <= tv_d;
      tc_q     <= tc_d;
      tt_q     <= tt_d;
      evCnt_q  <= evCnt_d;
    end
  end

  // readback registered: answer one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_q     <= 32'h0000_0000;
    end else begin
      rd_q     <= rd_d;
    end
  end

  // ----------------------------------------
  // sample storage
  // ----------------------------------------
  // no reset here; contents undefined until written
  always_ff @(posedge clock) begin
    if (storeWe) begin
      store[slot_q] <= sampleData;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // stream beats come straight from flops, so channel and type stand with valid
  assign bus.thrValid    = tv_q;
  assign bus.thrChannel  = tc_q;
  assign bus.thrType     = tt_q;
  assign bus.regReadData = rd_q;
  assign bus.irq         = eop_q & ier_q;
  assign runLevel        = run_q;
endmodule : acsi_device
`default_nettype wire

/* File: src/acsi_host.sv */
// acsi_host.sv: bus master and threshold sink facing the converter controller
// assumes: same clock and sys_rst as the device, released synchronously
`include "acsi_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module acsi_host (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  acsi_if.host               bus,
  input  wire logic          cmdValid,
  input  wire logic          cmdWrite,
  input  wire acsi_pkg::acsi_addr_t cmdAddr,
  input  wire acsi_pkg::acsi_word_t cmdData,
  output logic               cmdReady,
  output acsi_pkg::acsi_word_t rspData,
  output logic               rspValid,
  output acsi_pkg::acsi_chan_t lastChannel,
  output logic               lastAboveMax,
  output logic [15:0]        eventCount,
  output logic               packetSeen
);
  import acsi_pkg::*;

  // ----------------------------------------
  // master sequencer
  // ----------------------------------------
  acsi_host_state_t st_q, st_d;
  logic       rd_q, rd_d, wr_q, wr_d, rv_q, rv_d, rdPend_q, rdPend_d, pk_q, pk_d;
  logic       rdWait_q, rdWait_d;
  acsi_addr_t a_q, a_d;
  acsi_word_t wd_q, wd_d, rsp_q, rsp_d;
  acsi_chan_t ch_q, ch_d;
  logic       ty_q, ty_d;
  logic [15:0] cnt_q, cnt_d;

  // irq service has priority over user commands
  assign cmdReady = (st_q == ACSI_H_IDLE) && !bus.irq && !rdPend_q;

  always_comb begin
    st_d = st_q; rd_d = 1'b0; wr_d = 1'b0; a_d = a_q; wd_d = wd_q;
    rv_d = 1'b0; rsp_d = rsp_q; rdPend_d = 1'b0; pk_d = pk_q;
    ch_d = ch_q; ty_d = ty_q; cnt_d = cnt_q;
    rdWait_d = rdPend_q;
    // read data stands in the cycle after the strobe has been taken
    if (rdWait_q) begin
      rv_d  = 1'b1;
      rsp_d = bus.regReadData;
    end
    unique case (st_q)
      ACSI_H_IDLE: begin
        // clear write still on the bus: the same flag is not served twice
        if (bus.irq) begin
          if (!wr_q) begin
            st_d = ACSI_H_READ_ISR;
          end
        end else if (cmdValid && !rdPend_q) begin
          a_d = cmdAddr; wd_d = cmdData;
          wr_d = cmdWrite; rd_d = !cmdWrite; rdPend_d = !cmdWrite;
        end
      end
      ACSI_H_READ_ISR: begin
        a_d = `ACSI_OFF_ISR;
        rd_d = 1'b1;
        pk_d = 1'b1;
        st_d = ACSI_H_CLEAR;
      end
      ACSI_H_CLEAR: begin
        a_d = `ACSI_OFF_ISR; wd_d = 32'h0000_0001; wr_d = 1'b1;
        st_d = ACSI_H_IDLE;
      end
    endcase
    // every beat taken in its valid cycle: no ready exists
    if (bus.thrValid) begin
      ch_d  = bus.thrChannel;
      ty_d  = bus.thrType == ACSI_ABOVE_MAX;
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ACSI_H_IDLE; rd_q <= 1'b0; wr_q <= 1'b0; a_q <= 7'h00;
      wd_q <= 32'h0000_0000; rv_q <= 1'b0; rsp_q <= 32'h0000_0000;
      rdPend_q <= 1'b0; pk_q <= 1'b0; ch_q <= 5'h00; ty_q <= 1'b0;
      rdWait_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      st_q <= st_d; rd_q <= rd_d; wr_q <= wr_d; a_q <= a_d; wd_q <= wd_d;
      rv_q <= rv_d; rsp_q <= rsp_d; rdPend_q <= rdPend_d; pk_q <= pk_d;
      rdWait_q <= rdWait_d;
      ch_q <= ch_d; ty_q <= ty_d; cnt_q <= cnt_d;
    end
  end

  assign bus.regAddress   = a_q;
  assign bus.regRead      = rd_q;
  assign bus.regWrite     = wr_q;
  assign bus.regWriteData = wd_q;
  assign rspData      = rsp_q;
  assign rspValid     = rv_q;
  assign lastChannel  = ch_q;
  assign lastAboveMax = ty_q;
  assign eventCount   = cnt_q;
  assign packetSeen   = pk_q;
endmodule : acsi_host
`default_nettype wire

/* File: tb/acsi_properties.sv */
// acsi_properties.sv: concurrent checks on the link between the two ends
// assumes: instantiated in tb beside the acsi_if instance, one clock
`include "acsi_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module acsi_properties (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic                 thrValid,
  input wire acsi_pkg::acsi_chan_t thrChannel,
  input wire logic                 thrType,
  input wire acsi_pkg::acsi_addr_t regAddress,
  input wire logic                 regRead,
  input wire logic                 regWrite,
  input wire acsi_pkg::acsi_word_t regWriteData,
  input wire acsi_pkg::acsi_word_t regReadData,
  input wire logic                 irq
);
  import acsi_pkg::*;
  // ----------------------------------------
  // shadow of the enable bit
  // ----------------------------------------
  logic ierQ;
  always_ff @(posedge clock) begin
    if (sys_rst) ierQ <= 1'b1;
    else if (regWrite && regAddress == `ACSI_OFF_IER) ierQ <= regWriteData[0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_quiet_a: assert property ($fell(sys_rst) |-> !irq && !thrValid)
    else $error("output active after reset");
  chan_range_a: assert property (thrValid |-> thrChannel <= 5'h11)
    else $error("threshold channel out of range");
  rdata_idle_a: assert property (!regRead |=> regReadData == 32'h0)
    else $error("read data without read");
  irq_enable_a: assert property (irq |-> ierQ)
    else $error("irq while disabled");
  ier_mask_a: assert property (
    regWrite && regAddress == `ACSI_OFF_IER && !regWriteData[0] |=> !irq)
    else $error("irq not masked");
  ier_read_a: assert property (
    regRead && regAddress == `ACSI_OFF_IER |=> regReadData == {31'h0, $past(ierQ)})
    else $error("enable read wrong");
  isr_visible_a: assert property (
    regRead && irq && regAddress == `ACSI_OFF_ISR |=> regReadData == 32'h1)
    else $error("status hidden");
  unmapped_read_a: assert property (
    regRead && regAddress > 7'h43 |=> regReadData == 32'h0)
    else $error("unmapped read not zero");
  reserved_bits_a: assert property (
    regRead && regAddress == `ACSI_OFF_THR
    |=> regReadData[31:28] == 4'h0 && regReadData[15:12] == 4'h0)
    else $error("reserved bits set");
  cover property (thrValid && thrType == ACSI_ABOVE_MAX);
  cover property (thrValid && thrType == ACSI_BELOW_MIN);
  cover property (regRead && irq && regAddress == `ACSI_OFF_ISR);
endmodule : acsi_properties
`default_nettype wire

/* File: tb/tb.sv */
// tb.sv: both ends joined by acsi_if, driven from their user sides
// assumes: 20 MHz clock, sys_rst held two cycles
`timescale 1ns/1ns
`default_nettype none
module tb;
  import acsi_pkg::*;
  logic clock, sys_rst, sampleValid, sampleEnd, cmdValid, cmdWrite;
  acsi_chan_t sampleChannel;
  acsi_sample_t sampleData;
  acsi_addr_t cmdAddr;
  acsi_word_t cmdData, rspData;
  logic cmdReady, rspValid, lastAboveMax, packetSeen, runLevel;
  acsi_chan_t lastChannel;
  logic [15:0] eventCount;
  int failures, numChecks, cycles, nEv;
  logic [5:0] thrQ[$], lastEv;
  acsi_word_t rdQ[$];
  acsi_if bus ();
  acsi_device acsi_device_inst (.clock(clock), .sys_rst(sys_rst), .bus(bus),
    .sampleValid(sampleValid), .sampleChannel(sampleChannel), .sampleData(sampleData),
    .sampleEnd(sampleEnd), .runLevel(runLevel));
  acsi_host acsi_host_inst (.clock(clock), .sys_rst(sys_rst), .bus(bus),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspData(rspData), .rspValid(rspValid),
    .lastChannel(lastChannel), .lastAboveMax(lastAboveMax),
    .eventCount(eventCount), .packetSeen(packetSeen));
  acsi_properties acsi_properties_inst (.clock(clock), .sys_rst(sys_rst),
    .thrValid(bus.thrValid), .thrChannel(bus.thrChannel), .thrType(bus.thrType),
    .regAddress(bus.regAddress), .regRead(bus.regRead), .regWrite(bus.regWrite),
    .regWriteData(bus.regWriteData), .regReadData(bus.regReadData), .irq(bus.irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input acsi_word_t seen, input acsi_word_t exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // request held until the edge where cmdReady is high
  task automatic op(input logic w, input acsi_addr_t a, input acsi_word_t d);
    @(posedge clock);
    cmdValid <= 1'b1; cmdWrite <= w; cmdAddr <= a; cmdData <= d;
    @(negedge clock);
    while (cmdReady !== 1'b1) @(negedge clock);
    @(posedge clock);
    cmdValid <= 1'b0;
  endtask : op
  task automatic rd(input acsi_addr_t a, input acsi_word_t exp);
    rdQ.push_back(exp);
    op(1'b0, a, 32'h0);
  endtask : rd
  // one sample per call; caller drops sampleValid afterwards
  task automatic send(input acsi_chan_t ch, input acsi_sample_t d, input logic last);
    @(posedge clock);
    sampleValid <= 1'b1; sampleChannel <= ch; sampleData <= d; sampleEnd <= last;
    if (ch <= 5'h11 && (d > 12'h800 || d < 12'h100)) begin
      lastEv = {ch, d > 12'h800};
      thrQ.push_back(lastEv);
      nEv++;
    end
  endtask : send
  // ----------------------------------------
  // clock, timeout, monitor
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock; // also stands in for the converter clock
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      conclude();
    end
  end
  always @(posedge clock) if (!sys_rst) begin
    if (bus.thrValid === 1'b1) begin
      if (thrQ.size() == 0) chk("unexpected beat", 32'h1, 32'h0);
      else chk("beat", {bus.thrChannel, bus.thrType}, thrQ.pop_front());
    end
    if (rspValid === 1'b1) begin
      if (rdQ.size() == 0) chk("unexpected read", 32'h1, 32'h0);
      else chk("read", rspData, rdQ.pop_front());
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1; sampleValid = 1'b0; sampleEnd = 1'b0; sampleChannel = '0;
    sampleData = '0; cmdValid = 1'b0; cmdWrite = 1'b0; cmdAddr = '0; cmdData = '0;
    void'($urandom(32'hC015CA8C));
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(7'h40, 32'h1);
    rd(7'h41, 32'h0);
    rd(7'h43, 32'h0FFF0000);
    op(1'b1, 7'h43, 32'h08000100);
    rd(7'h43, 32'h08000100);
    op(1'b1, 7'h00, 32'h1);
    send(5'h11, 12'h800, 1'b0);
    send(5'h11, 12'h100, 1'b0);
    send(5'h11, 12'h801, 1'b0);
    send(5'h00, 12'h0FF, 1'b0);
    for (int i = 0; i < 40; i++)
      send(5'($urandom_range(0, 31)), 12'($urandom_range(0, 4095)), i == 39);
    @(posedge clock);
    sampleValid <= 1'b0;
    sampleEnd <= 1'b0;
    repeat (12) @(posedge clock);
    chk("packet seen", {31'h0, packetSeen}, 32'h1);
    chk("irq cleared", {31'h0, bus.irq}, 32'h0);
    chk("run", {31'h0, runLevel}, 32'h1);
    chk("events", {16'h0, eventCount}, nEv);
    chk("last", {lastChannel, lastAboveMax}, lastEv);
    rd(7'h42, nEv);
    rd(7'h01, 32'h0000_0100);
    op(1'b1, 7'h40, 32'h0);
    send(5'h03, 12'h400, 1'b1);
    @(posedge clock);
    sampleValid <= 1'b0;
    sampleEnd <= 1'b0;
    repeat (4) @(posedge clock);
    chk("masked irq", {31'h0, bus.irq}, 32'h0);
    rd(7'h41, 32'h1);
    rd(7'h40, 32'h0);
    rd(7'h50, 32'h0);
    rd(7'h00, 32'h0000_0400);
    op(1'b1, 7'h41, 32'h1);
    rd(7'h41, 32'h0);
    repeat (6) @(posedge clock);
    chk("pending", thrQ.size() + rdQ.size(), 32'h0);
    conclude();
  end
endmodule : tb
`default_nettype wire
